// *** rtl/ipvr_resolver.sv ***
// Interrupt priority vector resolver: picks the winning source, hands
// its vector, mask level and table address to the core sequencer.
// Assumes core_ack_i is a one-cycle pulse on clk_i, module sources are
// levels on clk_i, and pins are asynchronous.
//
// Behaviour
// - Every source owns a distinct vector and table entry.
// - Core fetches handler from table address of winning vector.
// - Pins and modules take software levels 0 to 15 from registers.
// - Sources sharing a field rank in fixed in-module order.
// - Reset clears every programmable level to zero.
// - Equal levels resolve by default order, lower vector first.
// - Nonmaskable source: fixed level 16, vector 11, offset 0x2C.
// - User break: fixed level 15, vector 12, offset 0x30.
// - Pins 0 to 7 use vectors 64 to 71, offset 0x100 up.
// - Pins 0-3 use low pin register nibbles, 4-7 high register.
// - Transfer ch0/ch1 share bits 15-12, vectors 72 and 74.
// - Transfer ch2/ch3 share bits 11-8, vectors 76 and 78.
// - Timer ch0 uses bits 7-4, vectors 80 to 82.
// - Timer ch1 uses bits 3-0, vectors 84 to 86.
// - Timer ch2 uses timer register bits 15-12, vectors 88 to 90.
// - A source at level zero is masked, never requested.
// - Accepted pin or module source loads its level into core mask.
// - Accepted nonmaskable source loads mask level 15.
`timescale 1ns/1ps
module ipvr_resolver (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Pins
  input wire logic nmi_pin_i,
  input wire logic [ipvr_pkg::IPVR_NPIN-1:0] irq_pin_n_i,
  // On-chip sources
  input wire logic ubrk_req_i,
  input wire logic [ipvr_pkg::IPVR_NXFER-1:0] transfer_end_i,
  input wire logic [ipvr_pkg::IPVR_NTMR-1:0] tmr_cmp_a_i,
  input wire logic [ipvr_pkg::IPVR_NTMR-1:0] tmr_cmp_b_i,
  input wire logic [ipvr_pkg::IPVR_NTMR-1:0] tmr_ovf_i,
  // Core sequencer
  input wire logic [3:0] core_mask_level_i,
  input wire logic [31:0] vec_base_i,
  input wire logic core_ack_i,
  output ipvr_pkg::ipvr_core_req_t core_req_o,
  output logic [31:0] irq_addr_o
);
  import ipvr_pkg::*;

  // ------------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------------

  // Nibble k of a priority register, k=3 is bits 15-12
  function automatic logic [3:0] nib(input logic [15:0] r,
                                     input int k);
    nib = r[k*IPVR_NIB_W +: IPVR_NIB_W];
  endfunction : nib

  // Byte-lane write of a 16-bit register
  function automatic logic [15:0] lane_wr(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] sel);
    lane_wr = old;
    if (sel[0]) begin
      lane_wr[7:0] = d[7:0];
    end
    if (sel[1]) begin
      lane_wr[15:8] = d[15:8];
    end
  endfunction : lane_wr

  // Effective level of source i in default order
  function automatic logic [4:0] src_level(input int i,
                                           input ipvr_prio_regs_t r);
    logic [3:0] n;
    n = 4'h0;
    if (i == 0) begin
      return IPVR_LVL_NMI;
    end else if (i == 1) begin
      return IPVR_LVL_UBRK;
    end else if (i < IPVR_SRC_PIN0 + 4) begin
      n = nib(r.pin_lo, 3 - (i - IPVR_SRC_PIN0));
    end else if (i < IPVR_SRC_XFER0) begin
      n = nib(r.pin_hi, 3 - (i - IPVR_SRC_PIN0 - 4));
    end else if (i < IPVR_SRC_XFER0 + 2) begin
      // channels 0 and 1 share a field
      n = nib(r.xfer_tmr, 3);
    end else if (i < IPVR_SRC_TMR0) begin
      // channels 2 and 3 share a field
      n = nib(r.xfer_tmr, 2);
    end else if (i < IPVR_SRC_TMR0 + IPVR_TMR_SRCS) begin
      n = nib(r.xfer_tmr, 1);
    end else if (i < IPVR_SRC_TMR2) begin
      n = nib(r.xfer_tmr, 0);
    end else begin
      n = nib(r.tmr_ser, 3);
    end
    return {1'b0, n};
  endfunction : src_level

  // ------------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------------
  logic nmi_q;
  logic nmi_d;
  logic [IPVR_NPIN-1:0] irq_n_q;

  // Nonmaskable pin, idle low
  ipvr_sync #(.W(1), .RST(1'b0)) u_nmi_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(nmi_pin_i),
    .q_o(nmi_q)
  );

  // Request pins, active low, idle high
  ipvr_sync #(.W(IPVR_NPIN), .RST(8'hFF)) u_irq_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(irq_pin_n_i),
    .q_o(irq_n_q)
  );

  // ------------------------------------------------------------------
  // Nonmaskable edge capture
  // ------------------------------------------------------------------
  logic nmi_pend;
  logic nmi_edge;
  logic nmi_taken;

  assign nmi_edge = nmi_q & ~nmi_d;
  assign nmi_taken = core_ack_i & core_req_o.req & core_req_o.nmi;

  // Delayed copy for rising-edge detection
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nmi_d <= 1'b0;
    end else begin
      nmi_d <= nmi_q;
    end
  end

  // Sticky pending; a new edge wins over the acknowledge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nmi_pend <= 1'b0;
    end else if (nmi_edge) begin
      nmi_pend <= 1'b1;
    end else if (nmi_taken) begin
      nmi_pend <= 1'b0;
    end
  end

  // ------------------------------------------------------------------
  // Pending vector in default order
  // ------------------------------------------------------------------
  logic [IPVR_NSRC-1:0] pend;

  // Gather sources, one bit per vector
  always_comb begin
    pend = '0;
    pend[0] = nmi_pend;
    pend[1] = ubrk_req_i;
    pend[IPVR_SRC_PIN0 +: IPVR_NPIN] = ~irq_n_q;
    pend[IPVR_SRC_XFER0 +: IPVR_NXFER] = transfer_end_i;
    for (int c = 0; c < IPVR_NTMR; c++) begin
      pend[IPVR_SRC_TMR0 + c*IPVR_TMR_SRCS] = tmr_cmp_a_i[c];
      pend[IPVR_SRC_TMR0 + c*IPVR_TMR_SRCS + 1] = tmr_cmp_b_i[c];
      pend[IPVR_SRC_TMR0 + c*IPVR_TMR_SRCS + 2] = tmr_ovf_i[c];
    end
  end

  // ------------------------------------------------------------------
  // Priority resolution
  // ------------------------------------------------------------------
  ipvr_prio_regs_t prio;
  logic [4:0] best_lvl;
  logic [IPVR_IDX_W-1:0] best_idx;
  logic [4:0] cand_lvl;

  // Scan in default order; only a strictly higher level displaces
  always_comb begin
    best_lvl = IPVR_LVL_NONE;
    best_idx = '0;
    cand_lvl = IPVR_LVL_NONE;
    for (int i = 0; i < IPVR_NSRC; i++) begin
      cand_lvl = src_level(i, prio);
      // level zero never beats the empty level
      if (pend[i] && (cand_lvl > best_lvl)) begin
        best_lvl = cand_lvl;
        best_idx = IPVR_IDX_W'(i);
      end
    end
  end

  // ------------------------------------------------------------------
  // Request to the core
  // ------------------------------------------------------------------
  ipvr_core_req_t next_req;
  logic [31:0] next_addr;
  logic win_nmi;

  assign win_nmi = (best_lvl != IPVR_LVL_NONE) &&
                   (best_idx == IPVR_SRC_NMI);

  // Form request, mask load level and table address
  always_comb begin
    next_req = '0;
    next_req.vec = IPVR_SRC_VEC[best_idx];
    next_req.nmi = win_nmi;
    next_req.lvl = win_nmi ? IPVR_MASK_NMI : best_lvl[3:0];
    next_req.req = win_nmi ||
                   ((best_lvl != IPVR_LVL_NONE) &&
                    (best_lvl[3:0] > core_mask_level_i));
    if (best_lvl == IPVR_LVL_NONE) begin
      next_req.vec = 8'h00;
    end
    next_addr = vec_base_i +
                {22'h00_0000, next_req.vec, 2'b00};
  end

  // Registered outputs to the core sequencer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_req_o <= '0;
      irq_addr_o <= 32'h0000_0000;
    end else begin
      core_req_o <= next_req;
      irq_addr_o <= next_addr;
    end
  end

  // ------------------------------------------------------------------
  // Last accepted source
  // ------------------------------------------------------------------
  ipvr_core_req_t last_acc;

  // Capture what the core took, for software readout
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_acc <= '0;
    end else if (core_ack_i && core_req_o.req) begin
      last_acc <= core_req_o;
    end
  end

  // ------------------------------------------------------------------
  // Wishbone slave
  // ------------------------------------------------------------------
  logic wb_hit;
  logic wb_wr;
  logic [31:0] next_rdat;

  assign wb_hit = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wb_wr = wb_hit & wb_we_i;

  // One-cycle ack, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_hit;
    end
  end

  // Priority registers, written by byte lane
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prio.pin_lo <= IPVR_PRIO_RST;
      prio.pin_hi <= IPVR_PRIO_RST;
      prio.xfer_tmr <= IPVR_PRIO_RST;
      prio.tmr_ser <= IPVR_PRIO_RST;
    end else if (wb_wr) begin
      case (wb_adr_i)
        IPVR_ADR_PIN_LO: begin
          prio.pin_lo <= lane_wr(prio.pin_lo, wb_dat_i, wb_sel_i);
        end
        IPVR_ADR_PIN_HI: begin
          prio.pin_hi <= lane_wr(prio.pin_hi, wb_dat_i, wb_sel_i);
        end
        IPVR_ADR_XFER_TMR: begin
          prio.xfer_tmr <= lane_wr(prio.xfer_tmr, wb_dat_i, wb_sel_i);
        end
        IPVR_ADR_TMR_SER: begin
          prio.tmr_ser <= lane_wr(prio.tmr_ser, wb_dat_i, wb_sel_i);
        end
        default: begin
        end
      endcase
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    next_rdat = 32'h0000_0000;
    case (wb_adr_i)
      IPVR_ADR_PIN_LO: next_rdat[15:0] = prio.pin_lo;
      IPVR_ADR_PIN_HI: next_rdat[15:0] = prio.pin_hi;
      IPVR_ADR_XFER_TMR: next_rdat[15:0] = prio.xfer_tmr;
      IPVR_ADR_TMR_SER: next_rdat[15:0] = prio.tmr_ser;
      IPVR_ADR_STATUS: begin
        next_rdat[IPVR_STS_REQ] = core_req_o.req;
        next_rdat[IPVR_STS_NMI] = nmi_pend;
        next_rdat[IPVR_STS_LVL +: 4] = core_req_o.lvl;
        next_rdat[IPVR_STS_VEC +: 8] = core_req_o.vec;
      end
      IPVR_ADR_LAST: begin
        next_rdat[IPVR_STS_REQ] = last_acc.req;
        next_rdat[IPVR_STS_NMI] = last_acc.nmi;
        next_rdat[IPVR_STS_LVL +: 4] = last_acc.lvl;
        next_rdat[IPVR_STS_VEC +: 8] = last_acc.vec;
      end
      IPVR_ADR_PEND: next_rdat[IPVR_NSRC-1:0] = pend;
      default: next_rdat = 32'h0000_0000;
    endcase
  end

  // Read data registered with the ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_hit && !wb_we_i) begin
      wb_dat_o <= next_rdat;
    end else begin
      wb_dat_o <= 32'h0000_0000;
    end
  end

endmodule : ipvr_resolver

// *** rtl/ipvr_pkg.sv ***
// Shared constants, types and source table of the priority vector resolver.
// Assumes a 50 MHz core clock and a Wishbone slave with 32-bit data.
package ipvr_pkg;

  // ------------------------------------------------------------------
  // Source set and table
  // ------------------------------------------------------------------
  localparam int IPVR_NSRC = 23;
  localparam int IPVR_IDX_W = 5;
  localparam int IPVR_NPIN = 8;
  localparam int IPVR_NXFER = 4;
  localparam int IPVR_NTMR = 3;

  // Source indices, in default order, highest first
  localparam logic [4:0] IPVR_SRC_NMI = 5'h00;
  localparam logic [4:0] IPVR_SRC_UBRK = 5'h01;
  localparam int IPVR_SRC_PIN0 = 2;
  localparam int IPVR_SRC_XFER0 = 10;
  localparam int IPVR_SRC_TMR0 = 14;
  localparam int IPVR_SRC_TMR2 = 20;
  localparam int IPVR_TMR_SRCS = 3;

  // One vector per source, lowest vector first
  localparam logic [7:0] IPVR_SRC_VEC [IPVR_NSRC] = '{
    8'h0B, 8'h0C,
    8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h47,
    8'h48, 8'h4A, 8'h4C, 8'h4E,
    8'h50, 8'h51, 8'h52,
    8'h54, 8'h55, 8'h56,
    8'h58, 8'h59, 8'h5A
  };

  // ------------------------------------------------------------------
  // Levels and vector table entries
  // ------------------------------------------------------------------
  localparam logic [4:0] IPVR_LVL_NMI = 5'h10;
  localparam logic [4:0] IPVR_LVL_UBRK = 5'h0F;
  localparam logic [3:0] IPVR_MASK_NMI = 4'hF;
  localparam logic [4:0] IPVR_LVL_NONE = 5'h00;
  localparam int IPVR_NIB_W = 4;
  localparam int IPVR_ENTRY_SHIFT = 2;

  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [7:0] IPVR_ADR_PIN_LO = 8'h00;
  localparam logic [7:0] IPVR_ADR_PIN_HI = 8'h04;
  localparam logic [7:0] IPVR_ADR_XFER_TMR = 8'h08;
  localparam logic [7:0] IPVR_ADR_TMR_SER = 8'h0C;
  localparam logic [7:0] IPVR_ADR_STATUS = 8'h10;
  localparam logic [7:0] IPVR_ADR_LAST = 8'h14;
  localparam logic [7:0] IPVR_ADR_PEND = 8'h18;
  localparam logic [15:0] IPVR_PRIO_RST = 16'h0000;
  localparam int IPVR_STS_REQ = 15;
  localparam int IPVR_STS_NMI = 14;
  localparam int IPVR_STS_LVL = 8;
  localparam int IPVR_STS_VEC = 0;

  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] pin_lo;
    logic [15:0] pin_hi;
    logic [15:0] xfer_tmr;
    logic [15:0] tmr_ser;
  } ipvr_prio_regs_t;

  typedef struct packed {
    logic req;
    logic nmi;
    logic [3:0] lvl;
    logic [7:0] vec;
  } ipvr_core_req_t;

endpackage : ipvr_pkg

// *** rtl/ipvr_sync.sv ***
// Two-stage synchroniser for pin inputs of the resolver.
// Assumes the inputs are asynchronous to clk_i; RST is the idle pin level.
`timescale 1ns/1ps
module ipvr_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Pin side
  input wire logic [W-1:0] d_i,
  // Clock side
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta;

  // Two flops; only the second stage is read
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meta <= RST;
      q_o <= RST;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule : ipvr_sync

// *** test/ipvr_resolver_monitor.sv ***
// Port checker of the priority vector resolver.
// Assumes it is bound to ipvr_resolver.
`timescale 1ns/1ps
module ipvr_resolver_monitor (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Bus
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  // Core side
  input wire logic nmi_pin_i,
  input wire logic [3:0] core_mask_level_i,
  input wire logic [31:0] vec_base_i,
  input wire ipvr_pkg::ipvr_core_req_t core_req_o,
  input wire logic [31:0] irq_addr_o
);
  import ipvr_pkg::*;
  // ----
  // Checks
  // ----
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  bus_answer_a: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("no ack");
  ack_pulse_a: assert property (
    wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  idle_data_a: assert property (
    !wb_ack_o |-> wb_dat_o == 32'h0) else $error("data outside ack");
  upper_zero_a: assert property (
    wb_ack_o |-> wb_dat_o[31:23] == 9'h000) else $error("upper bits set");
  zero_masked_a: assert property (
    core_req_o.req |-> core_req_o.lvl != 4'h0) else $error("level 0 sent");
  mask_gate_a: assert property (
    core_req_o.req && !core_req_o.nmi |->
    core_req_o.lvl > $past(core_mask_level_i)) else $error("below mask");
  nmi_entry_a: assert property (
    core_req_o.nmi |-> core_req_o.req && core_req_o.vec == 8'h0B &&
    core_req_o.lvl == 4'hF) else $error("bad nmi entry");
  ubrk_entry_a: assert property (
    core_req_o.req && core_req_o.vec == 8'h0C |->
    core_req_o.lvl == 4'hF) else $error("bad break level");
  table_addr_a: assert property (
    core_req_o.req |-> irq_addr_o ==
    $past(vec_base_i) + {22'h0, core_req_o.vec, 2'b00})
    else $error("bad table address");
  vec_set_a: assert property (
    core_req_o.req |-> core_req_o.vec inside {8'h0B, 8'h0C,
    [8'h40:8'h48], 8'h4A, 8'h4C, 8'h4E, [8'h50:8'h52],
    [8'h54:8'h56], [8'h58:8'h5A]}) else $error("bad vector");
  nmi_latency_a: assert property (
    $rose(nmi_pin_i) |-> ##[1:5] core_req_o.nmi) else $error("nmi late");
endmodule : ipvr_resolver_monitor

// *** test/ipvr_core_model.sv ***
// Behavioural core exception sequencer facing the resolver.
// Assumes the bench sets the mask and the accept pacing.
`timescale 1ns/1ps
module ipvr_core_model #(
  parameter logic [31:0] BASE = 32'h0000_4000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // From resolver
  input wire ipvr_pkg::ipvr_core_req_t req_i,
  input wire logic [31:0] addr_i,
  // Bench control
  input wire logic accept_i,
  input wire logic [3:0] wait_i,
  input wire logic mask_wr_i,
  input wire logic [3:0] mask_val_i,
  // To resolver and bench
  output logic [3:0] mask_o,
  output logic ack_o,
  output logic [31:0] base_o,
  output logic [31:0] fetch_o
);
  import ipvr_pkg::*;
  logic [3:0] cnt;
  logic [1:0] hold;
  assign base_o = BASE;
  // Accept pacing, held off while the new mask settles
  always_ff @(posedge clk_i) begin
    ack_o <= 1'b0;
    if (rst_i) begin
      cnt <= 4'h0;
      hold <= 2'h0;
    end else if (hold != 2'h0) begin
      hold <= hold - 2'h1;
    end else if (req_i.req && accept_i && cnt >= wait_i) begin
      ack_o <= 1'b1;
      cnt <= 4'h0;
      hold <= 2'h3;
    end else if (req_i.req && accept_i) begin
      cnt <= cnt + 4'h1;
    end else begin
      cnt <= 4'h0;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask_o <= 4'hF;
    end else if (mask_wr_i) begin
      mask_o <= mask_val_i;
    end else if (ack_o && req_i.req) begin
      mask_o <= req_i.lvl;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fetch_o <= 32'h0;
    end else if (ack_o && req_i.req) begin
      fetch_o <= addr_i;
    end
  end
endmodule : ipvr_core_model

// *** test/ipvr_resolver_test.sv ***
// Self-checking bench of the priority vector resolver.
// Assumes the core model and the monitor are compiled first.
`timescale 1ns/1ps
module ipvr_resolver_test;
  import ipvr_pkg::*;
  localparam logic [31:0] BASE = 32'h0000_4000;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, nmi = 1'b0;
  logic accept = 1'b0, mask_wr = 1'b0, core_ack;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, dat_o, addr, base, fetch;
  logic [3:0] wait_c = 4'h0, mask_val = 4'h0, mask;
  logic [22:0] src = 23'h0;
  ipvr_core_req_t req;
  int fails = 0;
  int checks_done = 0;

  always #10 clk_i = ~clk_i;

  ipvr_resolver DUT (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3),
    .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .nmi_pin_i(nmi), .irq_pin_n_i(~src[9:2]), .ubrk_req_i(src[1]),
    .transfer_end_i(src[13:10]),
    .tmr_cmp_a_i({src[20], src[17], src[14]}),
    .tmr_cmp_b_i({src[21], src[18], src[15]}),
    .tmr_ovf_i({src[22], src[19], src[16]}),
    .core_mask_level_i(mask), .vec_base_i(base), .core_ack_i(core_ack),
    .core_req_o(req), .irq_addr_o(addr));

  ipvr_core_model #(.BASE(BASE)) CORE (.clk_i(clk_i), .rst_i(rst_i),
    .req_i(req), .addr_i(addr), .accept_i(accept), .wait_i(wait_c),
    .mask_wr_i(mask_wr), .mask_val_i(mask_val), .mask_o(mask),
    .ack_o(core_ack), .base_o(base), .fetch_o(fetch));

  task report_and_stop;
    if (fails == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : report_and_stop

  task check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Classic single cycle, held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    rdat = dat_o;
    if (n >= 50) check(32'h0, 32'h1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    @(posedge clk_i);
  endtask : wb

  task rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    check(rdat, exp);
  endtask : rd

  task set_mask(input logic [3:0] m);
    mask_val <= m;
    mask_wr <= 1'b1;
    @(posedge clk_i);
    mask_wr <= 1'b0;
  endtask : set_mask

  // Lets pin syncs and output register settle
  task expect_req(input logic [13:0] exp, input logic [31:0] ea);
    repeat (6) @(posedge clk_i);
    check({18'h0, req}, {18'h0, exp});
    if (exp[13]) check(addr, ea);
  endtask : expect_req

  function automatic logic [7:0] ev(int i);
    if (i == 1) return 8'h0C;
    if (i < 10) return 8'(62 + i);
    if (i < 14) return 8'(72 + 2 * (i - 10));
    return 8'(80 + 4 * ((i - 14) / 3) + (i - 14) % 3);
  endfunction : ev

  function automatic logic [3:0] el(int i);
    if (i == 1) return 4'hF;
    if (i < 10) return 4'(i - 1);
    if (i < 14) return 4'(9 + (i - 10) / 2);
    return 4'(11 + (i - 14) / 3);
  endfunction : el

  function automatic logic [31:0] ta(logic [7:0] v);
    return BASE + {22'h0, v, 2'b00};
  endfunction : ta

  // ----
  // Main sequence
  // ----
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 16; a += 4) rd(8'(a), 32'h0);
    wb(1'b1, 8'h1C, 32'h0000_FFFF);
    rd(8'h1C, 32'h0);
    set_mask(4'h0);
    src <= 23'h7F_FFFC;
    expect_req(14'h0, 32'h0);
    rd(8'h18, 32'h007F_FFFC);
    wb(1'b1, 8'h00, 32'h0000_1234);
    wb(1'b1, 8'h04, 32'h0000_5678);
    wb(1'b1, 8'h08, 32'h0000_9ABC);
    wb(1'b1, 8'h0C, 32'h0000_D000);
    rd(8'h08, 32'h0000_9ABC);
    for (int i = 1; i < 23; i++) begin
      src <= 23'h1 << i;
      expect_req({2'b10, el(i), ev(i)}, ta(ev(i)));
    end
    src <= 23'h7 << 14;
    expect_req(14'h2B50, ta(8'h50));
    src <= 23'h6 << 14;
    expect_req(14'h2B51, ta(8'h51));
    src <= 23'h3 << 10;
    expect_req(14'h2948, ta(8'h48));
    wb(1'b1, 8'h04, 32'h0000_5674);
    src <= (23'h1 << 5) | (23'h1 << 9);
    expect_req(14'h2443, ta(8'h43));
    src <= (23'h1 << 2) | (23'h1 << 20);
    expect_req(14'h2D58, ta(8'h58));
    src <= 23'h1 << 20;
    set_mask(4'hD);
    expect_req(14'h0D58, 32'h0);
    set_mask(4'hC);
    expect_req(14'h2D58, ta(8'h58));
    src <= 23'h2;
    set_mask(4'hF);
    expect_req(14'h0F0C, 32'h0);
    set_mask(4'hE);
    expect_req(14'h2F0C, ta(8'h0C));
    src <= 23'h0;
    set_mask(4'h5);
    nmi <= 1'b1;
    expect_req(14'h3F0B, ta(8'h0B));
    rd(8'h10, 32'h0000_CF0B);
    accept <= 1'b1;
    wait_c <= 4'h2;
    expect_req(14'h0, 32'h0);
    check({28'h0, mask}, 32'hF);
    check(fetch, ta(8'h0B));
    rd(8'h14, 32'h0000_CF0B);
    nmi <= 1'b0;
    wait_c <= 4'h0;
    set_mask(4'h3);
    src <= 23'h1 << 10;
    expect_req(14'h0948, 32'h0);
    check({28'h0, mask}, 32'h9);
    check(fetch, ta(8'h48));
    report_and_stop();
  end

  // Hang guard, far beyond the few hundred cycles used
  initial begin
    repeat (5000) @(posedge clk_i);
    fails++;
    $display("ERROR %0t: watchdog expired", $time);
    report_and_stop();
  end
endmodule : ipvr_resolver_test

bind ipvr_resolver ipvr_resolver_monitor u_mon (.clk_i(clk_i),
  .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .nmi_pin_i(nmi_pin_i),
  .core_mask_level_i(core_mask_level_i), .vec_base_i(vec_base_i),
  .core_req_o(core_req_o), .irq_addr_o(irq_addr_o));
